// ===== core/carrier_modulator_space_control.sv
// space-period and extended-space control of an infrared carrier modulator
// assumes the carrier generator and time-base tick run on sys_clk_in
//
// Functional notes
// - space periods hold the output low, with no carrier
// - fsk mode with zero space count switches carriers without gap or glitch
// - fsk mode gives phase-coherent two-carrier output with programmed mark and space
// - fsk space length is space count times carrier generator periods
// - time, baseband and fsk modes can make spaces longer than the space count
// - extended-space bit makes the next period a space of mark plus space counts
// - while extended-space stays set, every period is space only, no mark
// - clearing extended-space resumes mark then space at the next period
// - extended space total is period length times periods the bit stays set
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module carrier_modulator_space_control (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [space_ctl_pkg::ADDR_W-1:0] addr_in,
    input wire logic [space_ctl_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [space_ctl_pkg::DATA_W-1:0] rd_data_out,
    input wire space_ctl_pkg::carrier_s carrier_in,
    input wire logic time_tick_in,
    output logic carrier_secondary_out,
    output logic infrared_output_pin_out
);
    import space_ctl_pkg::*;

    localparam int CNT_W = DATA_W + 1;
    localparam int MSC_RW_W = MSC_EXSP_BIT + 1;

    logic [DATA_W-1:0] mark_count_q, mark_count_d;
    logic [DATA_W-1:0] space_count_q, space_count_d;
    logic [MSC_RW_W-1:0] msc_q, msc_d;
    logic [DATA_W-1:0] rd_data_q, rd_data_d;

    mod_state_e state_q, state_d;
    period_cfg_s cfg_q, cfg_d;
    logic sel_q, sel_d;
    logic ir_q, ir_d;

    logic boundary;
    logic cnt_load;
    logic [CNT_W-1:0] cnt_load_val;
    logic cnt_tick;
    logic [CNT_W-1:0] cnt_value;
    logic cnt_done;
    logic enable;
    logic [DATA_W-1:0] status_word;

    assign enable = msc_q[MSC_EN_BIT];

    // register file
    always_comb begin
        mark_count_d = mark_count_q;
        space_count_d = space_count_q;
        msc_d = msc_q;
        rd_data_d = '0;
        if (wr_in) begin
            unique case (addr_in)
                MARK_COUNT_OFS: mark_count_d = wr_data_in;
                SPACE_COUNT_OFS: space_count_d = wr_data_in;
                MSC_OFS: msc_d = wr_data_in[MSC_RW_W-1:0];
                default: ;
            endcase
        end
        if (rd_in) begin
            unique case (addr_in)
                MARK_COUNT_OFS: rd_data_d = mark_count_q;
                SPACE_COUNT_OFS: rd_data_d = space_count_q;
                MSC_OFS: rd_data_d = status_word;
                default: rd_data_d = '0;
            endcase
        end
    end

    always_comb begin
        status_word = '0;
        status_word[MSC_RW_W-1:0] = msc_q;
        status_word[MSC_IN_MARK_BIT] = (state_q == ST_MARK);
        status_word[MSC_IN_SPACE_BIT] = (state_q == ST_SPACE);
        status_word[MSC_SECONDARY_BIT] = sel_q;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mark_count_q <= COUNT_RESET;
            space_count_q <= COUNT_RESET;
            msc_q <= MSC_RESET;
            rd_data_q <= '0;
        end else begin
            mark_count_q <= mark_count_d;
            space_count_q <= space_count_d;
            msc_q <= msc_d;
            rd_data_q <= rd_data_d;
        end
    end

    // fsk counts carrier periods, time and baseband count the time-base tick
    assign cnt_tick = cfg_q.fsk ? carrier_in.period_end : time_tick_in;

    // period sequencer
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        sel_d = sel_q;
        boundary = 1'b0;
        cnt_load = 1'b0;
        cnt_load_val = '0;
        unique case (state_q)
            ST_IDLE: boundary = enable;
            ST_MARK: begin
                if (cnt_done) begin
                    if (cfg_q.space_count == '0) begin
                        boundary = 1'b1;
                    end else begin
                        state_d = ST_SPACE;
                        cnt_load = 1'b1;
                        cnt_load_val = {1'b0, cfg_q.space_count};
                    end
                end
            end
            ST_SPACE: boundary = cnt_done;
        endcase
        if (boundary) begin
            cfg_d.mark_count = mark_count_q;
            cfg_d.space_count = space_count_q;
            cfg_d.ext = msc_q[MSC_EXSP_BIT];
            cfg_d.fsk = msc_q[MSC_FSK_BIT];
            cfg_d.baseband = msc_q[MSC_BASEBAND_BIT];
            cnt_load = 1'b1;
            if (msc_q[MSC_EXSP_BIT]) begin
                state_d = ST_SPACE;
                cnt_load_val = CNT_W'(mark_count_q) + CNT_W'(space_count_q);
            end else begin
                state_d = ST_MARK;
                cnt_load_val = {1'b0, mark_count_q};
                if (msc_q[MSC_FSK_BIT] && state_q != ST_IDLE) begin
                    sel_d = ~sel_q;
                end
            end
        end
        if (!enable) begin
            state_d = ST_IDLE;
            sel_d = 1'b0;
            cnt_load = 1'b0;
        end
        ir_d = (state_d == ST_MARK) && (cfg_d.baseband || carrier_in.level);
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_IDLE;
            cfg_q <= '0;
            sel_q <= 1'b0;
            ir_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            sel_q <= sel_d;
            ir_q <= ir_d;
        end
    end

    period_down_counter #(
        .WIDTH(CNT_W)
    ) u_period_counter (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .load_in(cnt_load),
        .load_val_in(cnt_load_val),
        .tick_in(cnt_tick),
        .count_out(cnt_value),
        .done_out(cnt_done)
    );

    assign rd_data_out = rd_data_q;
    assign carrier_secondary_out = sel_q;
    assign infrared_output_pin_out = ir_q;

    sequence s_ext_boundary;
        boundary && msc_q[MSC_EXSP_BIT];
    endsequence

    sequence s_ext_load;
        state_q == ST_SPACE && cnt_value == CNT_W'($past(mark_count_q)) + CNT_W'($past(space_count_q));
    endsequence

    sequence s_norm_boundary;
        boundary && enable && !msc_q[MSC_EXSP_BIT];
    endsequence

    sequence s_mark_load;
        state_q == ST_MARK && cnt_value == CNT_W'($past(mark_count_q));
    endsequence

    a_space_no_carrier: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        state_q == ST_SPACE |-> !infrared_output_pin_out) else $error("output active in space");
    a_disable_idle: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        !enable |=> state_q == ST_IDLE && !infrared_output_pin_out) else $error("output active while disabled");
    a_zero_space_skip: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        state_q == ST_MARK && cnt_done && cfg_q.space_count == '0 && enable && !msc_q[MSC_EXSP_BIT]
        |=> state_q == ST_MARK) else $error("zero space produced a gap");
    a_fsk_carrier_swap: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        boundary && enable && state_q != ST_IDLE && msc_q[MSC_FSK_BIT] && !msc_q[MSC_EXSP_BIT]
        |=> carrier_secondary_out != $past(carrier_secondary_out))
        else $error("fsk carrier not swapped");
    a_count_tick_only: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        state_q != ST_IDLE && !cnt_load && !cnt_tick |=> $stable(cnt_value))
        else $error("count moved without tick");
    a_ext_length: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        s_ext_boundary ##0 enable |=> s_ext_load) else $error("extended space length wrong");
    a_ext_no_mark: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        cfg_q.ext && state_q != ST_IDLE |-> state_q == ST_SPACE) else $error("mark during extended space");
    a_ext_clear_wait: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        cfg_q.ext && state_q == ST_SPACE && !cnt_done && enable |=> state_q == ST_SPACE)
        else $error("extended space cut short");
    a_mark_length: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        s_norm_boundary |=> s_mark_load) else $error("mark count not loaded");
    a_cfg_sampled: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        !boundary |=> $stable(cfg_q.mark_count) && $stable(cfg_q.ext))
        else $error("config changed mid period");
    a_mark_carrier: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        state_d == ST_MARK && !cfg_d.baseband ##1 state_q == ST_MARK
        |-> infrared_output_pin_out == $past(carrier_in.level)) else $error("mark not carrying carrier");
    a_baseband_high: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        state_q == ST_MARK && cfg_q.baseband |-> infrared_output_pin_out) else $error("baseband mark not high");
endmodule : carrier_modulator_space_control

// ===== core/space_ctl_pkg.sv
// package for the modulator space control, plus its period down counter
// assumes a single clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
package space_ctl_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 2;
    localparam logic [ADDR_W-1:0] MARK_COUNT_OFS = 2'h0;
    localparam logic [ADDR_W-1:0] SPACE_COUNT_OFS = 2'h1;
    localparam logic [ADDR_W-1:0] MSC_OFS = 2'h2;
    localparam int MSC_EN_BIT = 0;
    localparam int MSC_FSK_BIT = 1;
    localparam int MSC_BASEBAND_BIT = 2;
    localparam int MSC_EXSP_BIT = 3;
    localparam int MSC_IN_MARK_BIT = 4;
    localparam int MSC_IN_SPACE_BIT = 5;
    localparam int MSC_SECONDARY_BIT = 6;
    localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [3:0] MSC_RESET = 4'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_MARK, ST_SPACE} mod_state_e;

    // carrier generator output: current level and a pulse at the end of each period
    typedef struct packed {
        logic level;
        logic period_end;
    } carrier_s;

    // control snapshot taken at a period boundary
    typedef struct packed {
        logic [DATA_W-1:0] mark_count;
        logic [DATA_W-1:0] space_count;
        logic ext;
        logic fsk;
        logic baseband;
    } period_cfg_s;
endpackage : space_ctl_pkg

module period_down_counter #(
    parameter int WIDTH = 17
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] load_val_in,
    input wire logic tick_in,
    output logic [WIDTH-1:0] count_out,
    output logic done_out
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load_in) begin
            cnt_d = load_val_in;
        end else if (tick_in && cnt_q != '0) begin
            cnt_d = cnt_q - WIDTH'(1);
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count_out = cnt_q;
    assign done_out = (cnt_q == '0);
endmodule : period_down_counter

// ===== dv/carrier_gen_model.sv
// carrier generator model that feeds the space control block
// assumes the sys_clk_in domain; the carrier select changes only at a period end
`timescale 1ns/1ps
module carrier_gen_model (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic secondary_in,
    output space_ctl_pkg::carrier_s carrier_out
);
    import space_ctl_pkg::*;
    logic sec_q;
    logic [1:0] cnt_q;
    logic [1:0] last;
    assign last = sec_q ? 2'h3 : 2'h2;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 2'h0;
            sec_q <= 1'b0;
        end else if (cnt_q == last) begin
            cnt_q <= 2'h0;
            sec_q <= secondary_in;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    // primary is high 1 of 3 cycles, secondary high 3 of 4
    assign carrier_out = '{level: (sec_q ? (cnt_q != 2'h3) : (cnt_q == 2'h0)), period_end: (cnt_q == last)};
endmodule : carrier_gen_model

// ===== dv/testbench.sv
// testbench for the modulator space control
// assumes the carrier model above and a time-base tick every 4 clocks
`timescale 1ns/1ps
module testbench;
    import space_ctl_pkg::*;
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr = 2'h0;
    logic [DATA_W-1:0] wdat = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tick = 1'b0;
    logic [1:0] tcnt = 2'h0;
    logic [DATA_W-1:0] rdat;
    carrier_s car;
    logic sec;
    logic pin;
    int failures = 0;
    int check_count = 0;
    int h;
    int l;
    int n;

    carrier_modulator_space_control uut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .addr_in(addr),
        .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .carrier_in(car),
        .time_tick_in(tick), .carrier_secondary_out(sec), .infrared_output_pin_out(pin));
    carrier_gen_model cg (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .secondary_in(sec), .carrier_out(car));

    initial begin
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int v, input int lo, input int hi);
        chk(16'((v >= lo && v <= hi) ? 1 : 0), 16'h0001);
    endtask : chk_rng
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        @(negedge sys_clk_in);
        chk(rdat, exp);
        @(negedge sys_clk_in);
        chk(rdat, 16'h0000);
    endtask : rd_chk
    // waits for a mark, then measures mark and following gap in clocks
    task automatic runs(output int hi, output int lo);
        int k;
        k = 0;
        hi = 0;
        lo = 0;
        while (pin !== 1'b1 && k < 500) begin
            @(negedge sys_clk_in);
            k++;
        end
        while (pin === 1'b1 && hi < 500) begin
            @(negedge sys_clk_in);
            hi++;
        end
        while (pin === 1'b0 && lo < 500) begin
            @(negedge sys_clk_in);
            lo++;
        end
    endtask : runs
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        failures++;
        tally_and_finish;
    end

    initial begin
        repeat (8) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        rd_chk(MARK_COUNT_OFS, COUNT_RESET);
        rd_chk(SPACE_COUNT_OFS, COUNT_RESET);
        rd_chk(MSC_OFS, 16'h0000);
        wr_reg(2'h3, 16'hBEEF);
        rd_chk(2'h3, 16'h0000);
        wr_reg(MARK_COUNT_OFS, 16'h0003);
        wr_reg(SPACE_COUNT_OFS, 16'h0002);
        wr_reg(MSC_OFS, 16'h000E);
        rd_chk(MARK_COUNT_OFS, 16'h0003);
        rd_chk(SPACE_COUNT_OFS, 16'h0002);
        rd_chk(MSC_OFS, 16'h000E);
        // baseband: mark 3 ticks high, space 2 ticks low
        wr_reg(MSC_OFS, 16'h0005);
        runs(h, l);
        runs(h, l);
        chk_rng(h, 12, 17);
        chk_rng(l, 8, 13);
        // extended space: no mark for several whole periods
        wr_reg(MSC_OFS, 16'h000D);
        repeat (50) @(negedge sys_clk_in);
        n = 0;
        repeat (60) begin
            @(negedge sys_clk_in);
            n += (pin !== 1'b0);
        end
        chk_rng(n, 0, 0);
        rd_chk(MSC_OFS, 16'h002D);
        wr_reg(MSC_OFS, 16'h0005);
        n = 0;
        while (pin !== 1'b1 && n < 500) begin
            @(negedge sys_clk_in);
            n++;
        end
        chk_rng(n, 1, 28);
        // fsk, zero space: carriers alternate with no gap
        wr_reg(MSC_OFS, 16'h0000);
        wr_reg(SPACE_COUNT_OFS, 16'h0000);
        wr_reg(MSC_OFS, 16'h0003);
        h = 0;
        l = 0;
        n = 0;
        repeat (200) begin
            @(negedge sys_clk_in);
            n = (pin === 1'b0) ? n + 1 : 0;
            l = (n > l) ? n : l;
            h += (sec !== cg.sec_q);
        end
        chk_rng(l, 0, 3);
        chk_rng(h, 4, 200);
        // baseband, zero space: the mark runs on with no gap
        wr_reg(MSC_OFS, 16'h0000);
        wr_reg(MSC_OFS, 16'h0005);
        repeat (30) @(negedge sys_clk_in);
        n = 0;
        repeat (40) begin
            @(negedge sys_clk_in);
            n += (pin !== 1'b1);
        end
        chk_rng(n, 0, 0);
        rd_chk(MSC_OFS, 16'h0015);
        // time mode: a mark passes the primary carrier, high one clock in three
        wr_reg(MSC_OFS, 16'h0000);
        wr_reg(SPACE_COUNT_OFS, 16'h0002);
        wr_reg(MSC_OFS, 16'h0001);
        runs(h, l);
        chk_rng(h, 1, 1);
        // fsk, space of two carrier periods: 6 to 8 clocks plus a short carrier low tail
        wr_reg(MSC_OFS, 16'h0000);
        wr_reg(MSC_OFS, 16'h0003);
        l = 0;
        n = 0;
        repeat (200) begin
            @(negedge sys_clk_in);
            n = (pin === 1'b0) ? n + 1 : 0;
            l = (n > l) ? n : l;
        end
        chk_rng(l, 6, 11);
        tally_and_finish;
    end
endmodule : testbench
